// ===== hw/sgc_pkg.sv
// Constants and register map of the sound generator control block
package sgc_pkg;
   localparam int   ADDR_W   = 7;
   localparam int   PS_W     = 11;
   localparam int   TONE_W   = 10;
   localparam int   AMP_W    = 11;
   localparam int   DUR_W    = 8;
   // Register indices; byte address is four times the index
   localparam logic [4:0] IDX_CTRL = 5'h00;
   localparam logic [4:0] IDX_RAMP = 5'h01;
   localparam logic [4:0] IDX_PSH  = 5'h02;
   localparam logic [4:0] IDX_PSL  = 5'h03;
   localparam logic [4:0] IDX_TNH  = 5'h04;
   localparam logic [4:0] IDX_TNL  = 5'h05;
   localparam logic [4:0] IDX_AMH  = 5'h06;
   localparam logic [4:0] IDX_AML  = 5'h07;
   localparam logic [4:0] IDX_AAH  = 5'h08;
   localparam logic [4:0] IDX_AAL  = 5'h09;
   localparam logic [4:0] IDX_ATH  = 5'h0a;
   localparam logic [4:0] IDX_ATL  = 5'h0b;
   localparam logic [4:0] IDX_DUR  = 5'h0c;
   localparam int   B_EN     = 7;
   localparam int   B_MODE   = 2;
   localparam int   B_RDY    = 1;
   localparam int   B_HALT   = 0;
   localparam int   B_REN    = 7;
   localparam int   B_RTYP   = 1;
   localparam int   B_RDIR   = 0;
   localparam logic [1:0] RT_LIN  = 2'h0;
   localparam logic [1:0] RT_GONG = 2'h1;
   localparam logic [1:0] RT_EXP  = 2'h2;
   localparam int   EXP_SH   = 3;
   localparam logic [1:0] RESP_OK  = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;
   typedef enum logic [1:0] {GS_IDLE = 2'h1, GS_RUN = 2'h2} sgc_gs_t;
endpackage

// ===== hw/sgc_top.sv
// Sound generator control, prescaler and output stage with AXI4-Lite registers
`timescale 1ns/1ns
module sgc_top
(
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   input  wire logic [sgc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   input  wire logic [31:0]                s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   output logic [1:0]                      s_axi_bresp,
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   input  wire logic [sgc_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   output logic [31:0]                     s_axi_rdata,
   output logic [1:0]                      s_axi_rresp,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready,
   output logic                            tone_out_pin,
   output logic                            amplitude_out_pin
);
   localparam int PW = sgc_pkg::PS_W;
   localparam int TW = sgc_pkg::TONE_W;
   localparam int AW = sgc_pkg::AMP_W;
   localparam int DW = sgc_pkg::DUR_W;

   logic          wr_rdy_ff, nxt_wr_rdy;
   logic          bvalid_ff, nxt_bvalid;
   logic [1:0]    bresp_ff, nxt_bresp;
   logic          ar_rdy_ff, nxt_ar_rdy;
   logic          rvalid_ff, nxt_rvalid;
   logic [1:0]    rresp_ff, nxt_rresp;
   logic [31:0]   rdata_ff, nxt_rdata;
   logic          wr_fire, rd_fire, wen, cfg_wr, wmap, rmap;
   logic [4:0]    widx, ridx;
   logic [7:0]    wb, rb;

   logic          en_ff, nxt_en, mode_ff, nxt_mode;
   logic          rdy_ff, nxt_rdy, halt_ff, nxt_halt;
   logic          ren_ff, nxt_ren, rdir_ff, nxt_rdir;
   logic [1:0]    rtyp_ff, nxt_rtyp;
   logic [PW-1:0] ps_ff, nxt_ps;
   logic [TW-1:0] tn_ff, nxt_tn;
   logic [AW-1:0] am_ff, nxt_am, aa_ff, nxt_aa, at_ff, nxt_at;
   logic [DW-1:0] dr_ff, nxt_dr;

   sgc_pkg::sgc_gs_t gs_ff, nxt_gs;
   logic [PW-1:0] pcnt_ff, nxt_pcnt, psb_ff, nxt_psb;
   logic [TW-1:0] tcnt_ff, nxt_tcnt, tnb_ff, nxt_tnb;
   logic [DW-1:0] dcnt_ff, nxt_dcnt, drb_ff, nxt_drb;
   logic [AW-1:0] amb_ff, nxt_amb, aab_ff, nxt_aab;
   logic          tlvl_ff, nxt_tlvl, tpin_ff, nxt_tpin, apin_ff, nxt_apin;
   logic          run_now, tick, half, dur_end, pwm, reached;
   logic [AW:0]   inc, sum;

   // Bus handshake; one write and one read in flight
   assign wr_fire = wr_rdy_ff & s_axi_awvalid & s_axi_wvalid;
   assign rd_fire = ar_rdy_ff & s_axi_arvalid;
   assign widx    = s_axi_awaddr[sgc_pkg::ADDR_W-1:2];
   assign ridx    = s_axi_araddr[sgc_pkg::ADDR_W-1:2];
   assign wmap    = widx <= sgc_pkg::IDX_DUR;
   assign rmap    = ridx <= sgc_pkg::IDX_DUR;
   // Data sits in lane 0; other lanes carry only reserved bits
   assign wen     = wr_fire & wmap & s_axi_wstrb[0];
   assign wb      = s_axi_wdata[7:0];
   assign cfg_wr  = wen & (widx != sgc_pkg::IDX_CTRL);

   always_comb
   begin
      nxt_wr_rdy = s_axi_awvalid & s_axi_wvalid & ~wr_rdy_ff & ~bvalid_ff;
      nxt_bvalid = wr_fire | (bvalid_ff & ~s_axi_bready);
      nxt_bresp  = bresp_ff;
      if (wr_fire)
      begin
         nxt_bresp = wmap ? sgc_pkg::RESP_OK : sgc_pkg::RESP_ERR;
      end
      nxt_ar_rdy = s_axi_arvalid & ~ar_rdy_ff & ~rvalid_ff;
      nxt_rvalid = rd_fire | (rvalid_ff & ~s_axi_rready);
      nxt_rresp  = rresp_ff;
      nxt_rdata  = rdata_ff;
      if (rd_fire)
      begin
         nxt_rresp = rmap ? sgc_pkg::RESP_OK : sgc_pkg::RESP_ERR;
         nxt_rdata = {24'h000000, rb};
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wr_rdy_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         bresp_ff  <= sgc_pkg::RESP_OK;
         ar_rdy_ff <= 1'b0;
         rvalid_ff <= 1'b0;
         rresp_ff  <= sgc_pkg::RESP_OK;
         rdata_ff  <= 32'h00000000;
      end
      else
      begin
         wr_rdy_ff <= nxt_wr_rdy;
         bvalid_ff <= nxt_bvalid;
         bresp_ff  <= nxt_bresp;
         ar_rdy_ff <= nxt_ar_rdy;
         rvalid_ff <= nxt_rvalid;
         rresp_ff  <= nxt_rresp;
         rdata_ff  <= nxt_rdata;
      end
   end

   // Read mux of the live registers, unused bits zero
   always_comb
   begin
      rb = 8'h00;
      unique case (ridx)
         sgc_pkg::IDX_CTRL:
         begin
            rb[sgc_pkg::B_EN]   = en_ff;
            rb[sgc_pkg::B_MODE] = mode_ff;
            rb[sgc_pkg::B_RDY]  = rdy_ff;
            rb[sgc_pkg::B_HALT] = halt_ff;
         end
         sgc_pkg::IDX_RAMP:
         begin
            rb[sgc_pkg::B_REN]                 = ren_ff;
            rb[sgc_pkg::B_RTYP+1:sgc_pkg::B_RTYP] = rtyp_ff;
            rb[sgc_pkg::B_RDIR]                = rdir_ff;
         end
         sgc_pkg::IDX_PSH: rb[PW-9:0] = ps_ff[PW-1:8];
         sgc_pkg::IDX_PSL: rb = ps_ff[7:0];
         sgc_pkg::IDX_TNH: rb[TW-9:0] = tn_ff[TW-1:8];
         sgc_pkg::IDX_TNL: rb = tn_ff[7:0];
         sgc_pkg::IDX_AMH: rb[AW-9:0] = am_ff[AW-1:8];
         sgc_pkg::IDX_AML: rb = am_ff[7:0];
         sgc_pkg::IDX_AAH: rb[AW-9:0] = aa_ff[AW-1:8];
         sgc_pkg::IDX_AAL: rb = aa_ff[7:0];
         sgc_pkg::IDX_ATH: rb[AW-9:0] = at_ff[AW-1:8];
         sgc_pkg::IDX_ATL: rb = at_ff[7:0];
         sgc_pkg::IDX_DUR: rb = dr_ff;
         default: rb = 8'h00;
      endcase
   end

   // Register writes; no mode restriction on access
   always_comb
   begin
      nxt_en   = en_ff;
      nxt_mode = mode_ff;
      nxt_rdy  = rdy_ff;
      nxt_halt = halt_ff;
      nxt_ren  = ren_ff;
      nxt_rtyp = rtyp_ff;
      nxt_rdir = rdir_ff;
      nxt_ps   = ps_ff;
      nxt_tn   = tn_ff;
      nxt_am   = am_ff;
      nxt_aa   = aa_ff;
      nxt_at   = at_ff;
      nxt_dr   = dr_ff;
      if (cfg_wr)
      begin
         nxt_rdy = 1'b0;
      end
      if (wen)
      begin
         unique case (widx)
            sgc_pkg::IDX_CTRL:
            begin
               nxt_en   = wb[sgc_pkg::B_EN];
               nxt_mode = wb[sgc_pkg::B_MODE];
               nxt_rdy  = wb[sgc_pkg::B_RDY];
               nxt_halt = wb[sgc_pkg::B_HALT];
            end
            sgc_pkg::IDX_RAMP:
            begin
               nxt_ren  = wb[sgc_pkg::B_REN];
               nxt_rtyp = wb[sgc_pkg::B_RTYP+1:sgc_pkg::B_RTYP];
               nxt_rdir = wb[sgc_pkg::B_RDIR];
            end
            sgc_pkg::IDX_PSH: nxt_ps[PW-1:8] = wb[PW-9:0];
            sgc_pkg::IDX_PSL: nxt_ps[7:0] = wb;
            sgc_pkg::IDX_TNH: nxt_tn[TW-1:8] = wb[TW-9:0];
            sgc_pkg::IDX_TNL: nxt_tn[7:0] = wb;
            sgc_pkg::IDX_AMH: nxt_am[AW-1:8] = wb[AW-9:0];
            sgc_pkg::IDX_AML: nxt_am[7:0] = wb;
            sgc_pkg::IDX_AAH: nxt_aa[AW-1:8] = wb[AW-9:0];
            sgc_pkg::IDX_AAL: nxt_aa[7:0] = wb;
            sgc_pkg::IDX_ATH: nxt_at[AW-1:8] = wb[AW-9:0];
            sgc_pkg::IDX_ATL: nxt_at[7:0] = wb;
            sgc_pkg::IDX_DUR: nxt_dr = wb;
            default: nxt_dr = dr_ff;
         endcase
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         en_ff   <= 1'b0;
         mode_ff <= 1'b0;
         rdy_ff  <= 1'b0;
         halt_ff <= 1'b0;
         ren_ff  <= 1'b0;
         rtyp_ff <= sgc_pkg::RT_LIN;
         rdir_ff <= 1'b0;
         ps_ff   <= '0;
         tn_ff   <= '0;
         am_ff   <= '0;
         aa_ff   <= '0;
         at_ff   <= '0;
         dr_ff   <= '0;
      end
      else
      begin
         en_ff   <= nxt_en;
         mode_ff <= nxt_mode;
         rdy_ff  <= nxt_rdy;
         halt_ff <= nxt_halt;
         ren_ff  <= nxt_ren;
         rtyp_ff <= nxt_rtyp;
         rdir_ff <= nxt_rdir;
         ps_ff   <= nxt_ps;
         tn_ff   <= nxt_tn;
         am_ff   <= nxt_am;
         aa_ff   <= nxt_aa;
         at_ff   <= nxt_at;
         dr_ff   <= nxt_dr;
      end
   end

   // Generator timing from the buffered copies; the ramp threshold compares against the live at_ff
   assign run_now = (gs_ff == sgc_pkg::GS_RUN) & en_ff & ~halt_ff;
   assign tick    = pcnt_ff == psb_ff;
   assign half    = tick & (tcnt_ff == tnb_ff);
   // Cycles start high, so a duration ends on the rising toggle and every cycle is whole
   assign dur_end = half & ~tlvl_ff & (dcnt_ff == drb_ff);
   // Counter spans the whole tick period, so amplitude above it saturates
   assign pwm     = {1'b0, pcnt_ff} < {1'b0, amb_ff};
   assign reached = rdir_ff ? (amb_ff <= at_ff) : (amb_ff >= at_ff);

   // Ramp step size for the selected type
   always_comb
   begin
      inc = '0;
      unique case (rtyp_ff)
         sgc_pkg::RT_LIN:  inc = {1'b0, aab_ff};
         // Decay takes away the upper half, so an amplitude of one halves to zero
         sgc_pkg::RT_GONG: inc = rdir_ff ? {1'b0, amb_ff} - {2'b00, amb_ff[AW-1:1]} : {1'b0, amb_ff};
         sgc_pkg::RT_EXP:  inc = {1'b0, amb_ff >> sgc_pkg::EXP_SH} + 12'h001;
         default:          inc = '0;
      endcase
      // Attack saturates at full scale, decay at zero
      if (rdir_ff)
      begin
         sum = ({1'b0, amb_ff} > inc) ? {1'b0, amb_ff} - inc : '0;
      end
      else
      begin
         sum = {1'b0, amb_ff} + inc;
         if (sum[AW])
         begin
            sum = {1'b0, {AW{1'b1}}};
         end
      end
   end

   always_comb
   begin
      nxt_gs   = gs_ff;
      nxt_pcnt = pcnt_ff;
      nxt_tcnt = tcnt_ff;
      nxt_dcnt = dcnt_ff;
      nxt_tlvl = tlvl_ff;
      nxt_psb  = psb_ff;
      nxt_tnb  = tnb_ff;
      nxt_drb  = drb_ff;
      nxt_amb  = amb_ff;
      nxt_aab  = aab_ff;
      if (!en_ff || halt_ff)
      begin
         nxt_gs   = sgc_pkg::GS_IDLE;
         nxt_pcnt = '0;
         nxt_tcnt = '0;
         nxt_dcnt = '0;
         nxt_tlvl = 1'b0;
      end
      else
      begin
         unique case (gs_ff)
            sgc_pkg::GS_IDLE:
            begin
               if (rdy_ff)
               begin
                  nxt_gs   = sgc_pkg::GS_RUN;
                  nxt_tlvl = 1'b1;
                  nxt_psb  = ps_ff;
                  nxt_tnb  = tn_ff;
                  nxt_drb  = dr_ff;
                  nxt_amb  = am_ff;
                  nxt_aab  = aa_ff;
               end
            end
            sgc_pkg::GS_RUN:
            begin
               nxt_pcnt = tick ? '0 : pcnt_ff + 1'b1;
               if (tick)
               begin
                  nxt_tcnt = half ? '0 : tcnt_ff + 1'b1;
               end
               if (half)
               begin
                  nxt_tlvl = ~tlvl_ff;
                  if (!tlvl_ff)
                  begin
                     nxt_dcnt = dur_end ? '0 : dcnt_ff + 1'b1;
                  end
               end
               if (dur_end)
               begin
                  if (ren_ff)
                  begin
                     if (!reached)
                     begin
                        nxt_amb = sum[AW-1:0];
                     end
                  end
                  else if (rdy_ff)
                  begin
                     nxt_psb = ps_ff;
                     nxt_tnb = tn_ff;
                     nxt_drb = dr_ff;
                     nxt_amb = am_ff;
                     nxt_aab = aa_ff;
                  end
                  else
                  begin
                     nxt_gs   = sgc_pkg::GS_IDLE;
                     nxt_pcnt = '0;
                     nxt_tcnt = '0;
                     nxt_dcnt = '0;
                     nxt_tlvl = 1'b0;
                  end
               end
            end
         endcase
      end
      nxt_tpin = run_now & tlvl_ff & (mode_ff | pwm);
      nxt_apin = run_now & pwm;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         gs_ff   <= sgc_pkg::GS_IDLE;
         pcnt_ff <= '0;
         tcnt_ff <= '0;
         dcnt_ff <= '0;
         tlvl_ff <= 1'b0;
         psb_ff  <= '0;
         tnb_ff  <= '0;
         drb_ff  <= '0;
         amb_ff  <= '0;
         aab_ff  <= '0;
         tpin_ff <= 1'b0;
         apin_ff <= 1'b0;
      end
      else
      begin
         gs_ff   <= nxt_gs;
         pcnt_ff <= nxt_pcnt;
         tcnt_ff <= nxt_tcnt;
         dcnt_ff <= nxt_dcnt;
         tlvl_ff <= nxt_tlvl;
         psb_ff  <= nxt_psb;
         tnb_ff  <= nxt_tnb;
         drb_ff  <= nxt_drb;
         amb_ff  <= nxt_amb;
         aab_ff  <= nxt_aab;
         tpin_ff <= nxt_tpin;
         apin_ff <= nxt_apin;
      end
   end

   assign s_axi_awready     = wr_rdy_ff;
   assign s_axi_wready      = wr_rdy_ff;
   assign s_axi_bvalid      = bvalid_ff;
   assign s_axi_bresp       = bresp_ff;
   assign s_axi_arready     = ar_rdy_ff;
   assign s_axi_rvalid      = rvalid_ff;
   assign s_axi_rresp       = rresp_ff;
   assign s_axi_rdata       = rdata_ff;
   assign tone_out_pin      = tpin_ff;
   assign amplitude_out_pin = apin_ff;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   dis_clear_a: assert property (!en_ff |=> gs_ff == sgc_pkg::GS_IDLE && pcnt_ff == '0 && tcnt_ff == '0)
      else $error("Counters not cleared while disabled");
   mix_mode_a: assert property (run_now && tlvl_ff && !mode_ff && !pwm |=> !tone_out_pin)
      else $error("Mixed tone not gated by amplitude");
   solo_mode_a: assert property (run_now && tlvl_ff && mode_ff |=> tone_out_pin)
      else $error("Solo tone not driven");
   rdy_clear_a: assert property (cfg_wr |=> !rdy_ff)
      else $error("Data ready not cleared by config write");
   stop_nrdy_a: assert property (run_now && dur_end && !ren_ff && !rdy_ff |=> gs_ff == sgc_pkg::GS_IDLE)
      else $error("No stop on reload without data ready");
   rdy_read_a: assert property (rd_fire && ridx == sgc_pkg::IDX_CTRL
      |=> rdata_ff[sgc_pkg::B_RDY] == $past(rdy_ff))
      else $error("Data ready read wrong");
   halt_now_a: assert property (halt_ff |=> gs_ff == sgc_pkg::GS_IDLE
      ##1 !tone_out_pin && !amplitude_out_pin)
      else $error("Halt did not stop output");
   pres_cnt_a: assert property (run_now && !tick |=> pcnt_ff == $past(pcnt_ff) + 1'b1)
      else $error("Prescaler count skipped");
   tone_hold_a: assert property (run_now && !tick |=> $stable(tcnt_ff) && $stable(tlvl_ff))
      else $error("Tone advanced without tick");
   pwm_sat_a: assert property (run_now && amb_ff > psb_ff |=> amplitude_out_pin)
      else $error("Amplitude not saturated");
   rsv_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("Reserved read bits not zero");
   idle_low_a: assert property (!en_ff |=> !tone_out_pin && !amplitude_out_pin)
      else $error("Pins active while disabled");
endmodule // sgc_top

// ===== tb/sgc_amp_model.sv
// External amplifier model that measures the tone and amplitude pins
`timescale 1ns/1ns
module sgc_amp_model
(
   input  wire logic aclk,
   input  wire logic clr,
   input  wire logic tone_out_pin,
   input  wire logic amplitude_out_pin,
   output int        a_per,
   output int        a_high,
   output int        t_high,
   output int        a_cnt,
   output int        t_cnt,
   output int        mix_bad
);
   int   cyc;
   int   a_rise;
   int   a_run;
   int   t_run;
   logic a_q = 1'b0;
   logic t_q = 1'b0;

   // Passive load: it only listens, so run lengths are whole clock counts
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      a_q <= amplitude_out_pin;
      t_q <= tone_out_pin;
      a_run <= amplitude_out_pin ? a_run + 1 : 0;
      t_run <= tone_out_pin ? t_run + 1 : 0;
      if (amplitude_out_pin && !a_q)
      begin
         a_per  <= cyc - a_rise;
         a_rise <= cyc;
      end
      if (!amplitude_out_pin && a_q)
         a_high <= a_run;
      if (!tone_out_pin && t_q)
         t_high <= t_run;
      if (clr)
      begin
         a_cnt   <= 0;
         t_cnt   <= 0;
         mix_bad <= 0;
      end
      else
      begin
         a_cnt   <= a_cnt + int'(amplitude_out_pin);
         t_cnt   <= t_cnt + int'(tone_out_pin);
         mix_bad <= mix_bad + int'(tone_out_pin && !amplitude_out_pin);
      end
   end
endmodule // sgc_amp_model

// ===== tb/sgc_top_tb.sv
// Self-checking testbench of the sound generator control block
`timescale 1ns/1ns
module sgc_top_tb;
   logic        aclk;
   logic        aresetn;
   logic [6:0]  awaddr, araddr;
   logic        awvalid, wvalid, bready, arvalid, rready, clr;
   logic [31:0] wdata;
   logic [3:0]  wstrb;
   logic        awready, wready, bvalid, arready, rvalid, tone, ampl;
   logic [1:0]  bresp, rresp, wrsp, rrsp;
   logic [31:0] rdata, rdat, seed;
   int          a_per, a_high, t_high, a_cnt, t_cnt, mix_bad;
   int          n_mismatch, tests_run, ps, tn, am;

   sgc_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tone_out_pin(tone),
      .amplitude_out_pin(ampl));

   sgc_amp_model amp (.aclk(aclk), .clr(clr), .tone_out_pin(tone), .amplitude_out_pin(ampl),
      .a_per(a_per), .a_high(a_high), .t_high(t_high), .a_cnt(a_cnt), .t_cnt(t_cnt), .mix_bad(mix_bad));

   initial
   begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Readable bits of each register
   function automatic logic [7:0] msk(input logic [4:0] i);
      case (i)
         5'h00, 5'h01: return 8'h87;
         5'h02, 5'h06, 5'h08, 5'h0a: return 8'h07;
         5'h04: return 8'h03;
         default: return 8'hff;
      endcase
   endfunction

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [4:0] idx, input logic [7:0] d);
      int n;
      @(posedge aclk);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do
      begin
         @(posedge aclk);
         n++;
         if (awready)
         begin
            awvalid <= 1'b0;
            wvalid <= 1'b0;
         end
      end
      while (!bvalid && n < 50);
      wrsp = bresp;
      bready <= 1'b0;
      chk(32'(n < 50), 32'h1);
   endtask

   task automatic rd(input logic [4:0] idx);
      int n;
      @(posedge aclk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do
      begin
         @(posedge aclk);
         n++;
         if (arready)
            arvalid <= 1'b0;
      end
      while (!rvalid && n < 50);
      rdat = rdata;
      rrsp = rresp;
      rready <= 1'b0;
      chk(32'(n < 50), 32'h1);
   endtask

   // Clear the load's counters, then let it listen for n cycles
   task automatic measure(input int n);
      clr <= 1'b1;
      @(posedge aclk);
      clr <= 1'b0;
      repeat (n) @(posedge aclk);
      #1;
   endtask

   task automatic cfg(input int p, input int t, input int a, input int d, input logic [7:0] r);
      wr(5'h00, 8'h00);
      wr(5'h01, r);
      wr(5'h02, 8'(p >> 8));
      wr(5'h03, 8'(p));
      wr(5'h04, 8'(t >> 8));
      wr(5'h05, 8'(t));
      wr(5'h06, 8'(a >> 8));
      wr(5'h07, 8'(a));
      wr(5'h0c, 8'(d));
   endtask

   // Start a long tone, stop it with the given control byte, expect silent pins
   task automatic stop_chk(input logic [7:0] c);
      wr(5'h00, 8'h86);
      repeat (60) @(posedge aclk);
      wr(5'h00, c);
      measure(100);
      chk(32'(a_cnt + t_cnt), 32'h0);
   endtask

   initial
   begin
      repeat (20000) @(posedge aclk);
      n_mismatch++;
      complete_run();
   end

   initial
   begin
      aresetn = 1'b0;
      {awaddr, araddr, wdata} = '0;
      {awvalid, wvalid, bready, arvalid, rready, clr} = '0;
      wstrb = 4'hf;
      seed = 32'h1e83;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i <= 12; i++)
      begin
         rd(5'(i));
         chk(rdat, 32'h0);
      end
      for (int i = 1; i <= 12; i++)
      begin
         seed = lfsr(seed);
         wr(5'h00, 8'h02);
         rd(5'h00);
         chk(rdat, 32'h2);
         wr(5'(i), seed[7:0]);
         rd(5'(i));
         chk(rdat, {24'h0, seed[7:0] & msk(5'(i))});
         rd(5'h00);
         chk(rdat, 32'h0);
      end
      wr(5'h00, 8'h7d);
      rd(5'h00);
      chk(rdat, 32'h5);
      for (int t = 0; t < 4; t++)
      begin
         wr(5'h01, {1'b1, 4'h0, 2'(t), t[0]});
         rd(5'h01);
         chk(rdat, {24'h0, 1'b1, 4'h0, 2'(t), t[0]});
      end
      wr(5'h0d, 8'hff);
      chk(32'(wrsp), 32'(sgc_pkg::RESP_ERR));
      rd(5'h0d);
      chk(32'(rrsp), 32'(sgc_pkg::RESP_ERR));
      chk(rdat, 32'h0);
      // Small prescaler values keep the run short; amplifier range is not the point here
      for (int k = 0; k < 2; k++)
      begin
         seed = lfsr(seed);
         ps = 3 + int'(seed[2:0]);
         tn = int'(seed[4:3]);
         am = 1 + int'(seed[7:5]) % ps;
         cfg(ps, tn, am, 255, 8'h00);
         wr(5'h00, 8'h86);
         repeat (200) @(posedge aclk);
         measure(200);
         chk(32'(a_per), 32'(ps + 1));
         chk(32'(a_high), 32'(am));
         chk(32'(t_high), 32'((tn + 1) * (ps + 1)));
         chk(32'(mix_bad != 0), 32'h1);
         wr(5'h00, 8'h82);
         measure(200);
         chk(32'({mix_bad != 0, t_cnt != 0}), 32'h1);
      end
      // Lowest prescaler that keeps the amplifier in its range
      cfg(255, 0, 128, 255, 8'h00);
      wr(5'h00, 8'h86);
      repeat (600) @(posedge aclk);
      measure(600);
      chk(32'(a_per), 32'd256);
      chk(32'(a_high), 32'd128);
      cfg(3, 0, 2, 1, 8'h00);
      wr(5'h00, 8'h86);
      repeat (40) @(posedge aclk);
      measure(40);
      chk(32'(t_cnt != 0), 32'h1);
      wr(5'h03, 8'h03);
      repeat (60) @(posedge aclk);
      measure(60);
      chk(32'(a_cnt + t_cnt), 32'h0);
      cfg(7, 1, 3, 255, 8'h00);
      stop_chk(8'h87);
      stop_chk(8'h06);
      cfg(15, 1, 1, 0, 8'h80);
      wr(5'h08, 8'h00);
      wr(5'h09, 8'h03);
      wr(5'h0a, 8'h07);
      wr(5'h0b, 8'hff);
      wr(5'h00, 8'h86);
      repeat (1300) @(posedge aclk);
      measure(100);
      chk(32'(a_cnt), 32'd100);
      // Gong and exponential decay towards a zero threshold must silence the amplitude pin
      wr(5'h0a, 8'h00);
      wr(5'h0b, 8'h00);
      for (int ty = 1; ty < 3; ty++)
      begin
         cfg(15, 0, 40, 0, {1'b1, 4'h0, 2'(ty), 1'b1});
         wr(5'h00, 8'h86);
         repeat (900) @(posedge aclk);
         measure(100);
         chk(32'(a_cnt), 32'h0);
      end
      complete_run();
   end
endmodule // sgc_top_tb
